// File: src/pll2_cfg_defs.vh
// addresses, field positions, reset values and scaling for the second pll config bank
`ifndef PLL2_CFG_DEFS_VH
`define PLL2_CFG_DEFS_VH

// bit widths of the host configuration port
`define CFG_ADDR_W 16
`define CFG_DATA_W 8

// byte addresses of the register bytes held here
`define ADDR_MODE 16'h0201
`define ADDR_CAL_LO 16'h0202
`define ADDR_CAL_HI 16'h0203
`define ADDR_NUM_0 16'h0204
`define ADDR_NUM_1 16'h0205
`define ADDR_NUM_2 16'h0206
`define ADDR_DEN_0 16'h0208
`define ADDR_DEN_1 16'h0209
`define ADDR_DEN_2 16'h020A
`define ADDR_DITHER 16'h020C
`define ADDR_PUMP 16'h020D
`define ADDR_CORES 16'h020E
`define ADDR_SRC_SNK 16'h020F

// field positions inside their bytes
`define POS_FRAC_SEL 7
`define POS_CAL_EN 7
`define POS_DITH_EN 6
`define POS_DITH_NS 5
`define POS_DITH_GAIN 3
`define POS_ORDER 1
`define POS_PUMP_EN 7
`define POS_SOURCE 4
`define POS_SINK 0

// reset values
`define RST_FRAC_SEL 1'h1
`define RST_CAL_DIV 14'h0675
`define RST_CAL_EN 1'h0
`define RST_NUM 24'h43_0000
`define RST_DEN 24'h7D_0000
`define RST_DITH_EN 1'h0
`define RST_DITH_NS 1'h0
`define RST_DITH_GAIN 2'h0
`define RST_ORDER 2'h3
`define RST_PUMP_EN 1'h1
`define RST_CORES 4'hF
`define RST_SOURCE 4'hF
`define RST_SINK 4'h0

// per-core current steps in microamps
`define SOURCE_STEP_UA 12'h01F4
`define SINK_STEP_UA 12'h00FA

`endif

// File: src/pll2_cfg_bank.v
// configuration bank for the second synth pll: calibration, modulator, charge pump
`timescale 1ns/1ps
`include "pll2_cfg_defs.vh"

// Contract
// - calibration reference: other pll or crystal
// - calibration enable bit runs vco band search
// - denominator 24-bit read/write, resets 0x7D0000
// - dither enable bit, off at reset
// - dither shaping bit, unshaped at reset
// - dither gain 1,2,4,8 lsb, resets 00
// - modulator order none to third, resets third
// - pump enable gates current, resets on
// - four core enables, additive, reset all on
// - source current 500ua per enabled source core
// - sink current 250ua per enabled sink core
// - fractional select adds num/den fraction
module pll2_cfg_bank (
    input wire clk, // 40 mhz system clock
    input wire sys_rst, // synchronous reset, active high
    input wire [`CFG_ADDR_W-1:0] cfg_addr, // byte address from config port
    input wire [`CFG_DATA_W-1:0] cfg_wdata, // write byte
    input wire cfg_wr, // one-cycle write strobe
    input wire cfg_rd, // one-cycle read strobe
    input wire synth_standalone, // mode bit: 1 standalone synth, 0 serves dpll
    output reg [`CFG_DATA_W-1:0] cfg_rdata, // read byte, one cycle after cfg_rd
    output reg cfg_rvalid, // pulse marking cfg_rdata
    output reg cfg_hit, // pulse: last access hit this bank
    output reg [13:0] vco_cal_ref_divisor, // calibration divisor
    output reg vco_cal_enable, // calibration enable
    output reg cal_ref_from_crystal, // calibration ref is crystal
    output reg fractional_mode_select, // fractional feedback division on
    output reg [23:0] frac_numerator, // modulator numerator
    output reg [23:0] frac_denominator, // modulator denominator
    output reg frac_ratio_ok, // numerator below denominator
    output reg mod_dither_enable, // dither on
    output reg mod_dither_shaping, // dither noise shaped
    output reg [1:0] mod_dither_gain, // dither gain code
    output reg [3:0] dither_amplitude_lsb, // dither amplitude in lsbs
    output reg [1:0] mod_order, // modulator order code
    output reg pump_enable, // charge pump current enable
    output reg [3:0] pump_core_enables, // per-core enable
    output reg [3:0] pump_source_enables, // per-core source enable
    output reg [3:0] pump_sink_enables, // per-core sink enable
    output reg [11:0] pump_source_ua, // total source current, microamps
    output reg [11:0] pump_sink_ua // total sink current, microamps
);

    // number of set bits in a nibble; used for source and sink cores
    function [2:0] count4;
        input [3:0] v;
        begin
            count4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
        end
    endfunction

    // current in microamps for a count of active cores at a given step
    function [11:0] core_current;
        input [2:0] cores;
        input [11:0] step;
        reg [14:0] prod;
        begin
            prod = {12'h000, cores} * {3'h0, step};
            core_current = prod[11:0];
        end
    endfunction

    // decoded write strobes, one per byte address
    wire wr_mode = cfg_wr && (cfg_addr == `ADDR_MODE);
    wire wr_cal_lo = cfg_wr && (cfg_addr == `ADDR_CAL_LO);
    wire wr_cal_hi = cfg_wr && (cfg_addr == `ADDR_CAL_HI);
    wire wr_num_0 = cfg_wr && (cfg_addr == `ADDR_NUM_0);
    wire wr_num_1 = cfg_wr && (cfg_addr == `ADDR_NUM_1);
    wire wr_num_2 = cfg_wr && (cfg_addr == `ADDR_NUM_2);
    wire wr_den_0 = cfg_wr && (cfg_addr == `ADDR_DEN_0);
    wire wr_den_1 = cfg_wr && (cfg_addr == `ADDR_DEN_1);
    wire wr_den_2 = cfg_wr && (cfg_addr == `ADDR_DEN_2);
    wire wr_dither = cfg_wr && (cfg_addr == `ADDR_DITHER);
    wire wr_pump = cfg_wr && (cfg_addr == `ADDR_PUMP);
    wire wr_cores = cfg_wr && (cfg_addr == `ADDR_CORES);
    wire wr_src_snk = cfg_wr && (cfg_addr == `ADDR_SRC_SNK);

    // read mux result and hit flag, combinational
    reg [`CFG_DATA_W-1:0] next_rdata; // byte for the addressed register
    reg next_hit; // address belongs to this bank

    // field storage; every field keeps its reset value until written
    always @(posedge clk) begin
        if (sys_rst) begin
            fractional_mode_select <= `RST_FRAC_SEL;
            vco_cal_ref_divisor <= `RST_CAL_DIV;
            vco_cal_enable <= `RST_CAL_EN;
            frac_numerator <= `RST_NUM;
            frac_denominator <= `RST_DEN;
            mod_dither_enable <= `RST_DITH_EN;
            mod_dither_shaping <= `RST_DITH_NS;
            mod_dither_gain <= `RST_DITH_GAIN;
            mod_order <= `RST_ORDER;
            pump_enable <= `RST_PUMP_EN;
            pump_core_enables <= `RST_CORES;
            pump_source_enables <= `RST_SOURCE;
            pump_sink_enables <= `RST_SINK;
        end else begin
            // mode byte: only the fractional select lives here
            if (wr_mode) begin
                fractional_mode_select <= cfg_wdata[`POS_FRAC_SEL];
            end
            // divisor split over two bytes, no shadowing between them
            if (wr_cal_lo) begin
                vco_cal_ref_divisor[7:0] <= cfg_wdata;
            end
            if (wr_cal_hi) begin
                vco_cal_ref_divisor[13:8] <= cfg_wdata[5:0];
                vco_cal_enable <= cfg_wdata[`POS_CAL_EN];
            end
            // numerator bytes; the ordering check is software's job
            if (wr_num_0) begin
                frac_numerator[7:0] <= cfg_wdata;
            end
            if (wr_num_1) begin
                frac_numerator[15:8] <= cfg_wdata;
            end
            if (wr_num_2) begin
                frac_numerator[23:16] <= cfg_wdata;
            end
            // denominator takes any value, zero included
            if (wr_den_0) begin
                frac_denominator[7:0] <= cfg_wdata;
            end
            if (wr_den_1) begin
                frac_denominator[15:8] <= cfg_wdata;
            end
            if (wr_den_2) begin
                frac_denominator[23:16] <= cfg_wdata;
            end
            // modulator dither and order byte
            if (wr_dither) begin
                mod_dither_enable <= cfg_wdata[`POS_DITH_EN];
                mod_dither_shaping <= cfg_wdata[`POS_DITH_NS];
                mod_dither_gain <= cfg_wdata[`POS_DITH_GAIN +: 2];
                mod_order <= cfg_wdata[`POS_ORDER +: 2];
            end
            // pump master enable; offset bits in this byte belong elsewhere
            if (wr_pump) begin
                pump_enable <= cfg_wdata[`POS_PUMP_EN];
            end
            // core enables in the low nibble; boost bits not held here
            if (wr_cores) begin
                pump_core_enables <= cfg_wdata[3:0];
            end
            if (wr_src_snk) begin
                pump_source_enables <= cfg_wdata[`POS_SOURCE +: 4];
                pump_sink_enables <= cfg_wdata[`POS_SINK +: 4];
            end
        end
    end

    // read mux; reserved bits and bits owned elsewhere read as zero
    always @* begin
        next_rdata = 8'h00;
        next_hit = 1'b1;
        case (cfg_addr)
            `ADDR_MODE: begin
                next_rdata[`POS_FRAC_SEL] = fractional_mode_select;
            end
            `ADDR_CAL_LO: begin
                next_rdata = vco_cal_ref_divisor[7:0];
            end
            `ADDR_CAL_HI: begin
                next_rdata[5:0] = vco_cal_ref_divisor[13:8];
                next_rdata[`POS_CAL_EN] = vco_cal_enable;
            end
            `ADDR_NUM_0: begin
                next_rdata = frac_numerator[7:0];
            end
            `ADDR_NUM_1: begin
                next_rdata = frac_numerator[15:8];
            end
            `ADDR_NUM_2: begin
                next_rdata = frac_numerator[23:16];
            end
            `ADDR_DEN_0: begin
                next_rdata = frac_denominator[7:0];
            end
            `ADDR_DEN_1: begin
                next_rdata = frac_denominator[15:8];
            end
            `ADDR_DEN_2: begin
                next_rdata = frac_denominator[23:16];
            end
            `ADDR_DITHER: begin
                next_rdata[`POS_DITH_EN] = mod_dither_enable;
                next_rdata[`POS_DITH_NS] = mod_dither_shaping;
                next_rdata[`POS_DITH_GAIN +: 2] = mod_dither_gain;
                next_rdata[`POS_ORDER +: 2] = mod_order;
            end
            `ADDR_PUMP: begin
                next_rdata[`POS_PUMP_EN] = pump_enable;
            end
            `ADDR_CORES: begin
                next_rdata[3:0] = pump_core_enables;
            end
            `ADDR_SRC_SNK: begin
                next_rdata[`POS_SOURCE +: 4] = pump_source_enables;
                next_rdata[`POS_SINK +: 4] = pump_sink_enables;
            end
            default: begin
                // not ours: answer zero and flag the miss
                next_hit = 1'b0;
            end
        endcase
    end

    // read answer registered one cycle after the strobe
    always @(posedge clk) begin
        if (sys_rst) begin
            cfg_rdata <= 8'h00;
            cfg_rvalid <= 1'b0;
            cfg_hit <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            cfg_hit <= (cfg_rd || cfg_wr) && next_hit;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // derived state for the analog side, registered so it never glitches
    always @(posedge clk) begin
        if (sys_rst) begin
            cal_ref_from_crystal <= 1'b0;
            frac_ratio_ok <= 1'b1;
            dither_amplitude_lsb <= 4'h1;
            pump_source_ua <= 12'h000;
            pump_sink_ua <= 12'h000;
        end else begin
            // standalone uses another pll as reference, dpll use the crystal
            cal_ref_from_crystal <= ~synth_standalone;
            // status only; the divider is not blocked on a bad ratio
            frac_ratio_ok <= (frac_numerator < frac_denominator);
            // gain code selects a power of two amplitude
            dither_amplitude_lsb <= 4'h1 << mod_dither_gain;
            // a core counts only when its core bit and direction bit are set
            if (pump_enable) begin
                pump_source_ua <= core_current(count4(pump_core_enables & pump_source_enables),
                    `SOURCE_STEP_UA);
                pump_sink_ua <= core_current(count4(pump_core_enables & pump_sink_enables),
                    `SINK_STEP_UA);
            end else begin
                // pump disabled: no current in either direction
                pump_source_ua <= 12'h000;
                pump_sink_ua <= 12'h000;
            end
        end
    end

endmodule

// File: tb/pll2_cfg_bank_properties.sv
// port assertions for the second pll configuration bank
`timescale 1ns/1ps
module pll2_cfg_bank_properties (
    input wire clk, // system clock
    input wire sys_rst, // sync reset
    input wire [15:0] cfg_addr, // byte address
    input wire [7:0] cfg_wdata, // write byte
    input wire cfg_wr, // write strobe
    input wire cfg_rd, // read strobe
    input wire synth_standalone, // mode input
    input wire cfg_rvalid, // read answer
    input wire cfg_hit, // mapped access flag
    input wire cal_ref_from_crystal, // calibration source
    input wire [23:0] frac_numerator, // numerator
    input wire [23:0] frac_denominator, // denominator
    input wire frac_ratio_ok, // num below den
    input wire [1:0] mod_dither_gain, // gain code
    input wire [3:0] dither_amplitude_lsb, // decoded gain
    input wire [1:0] mod_order, // order code
    input wire pump_enable, // pump on
    input wire [3:0] pump_core_enables, // cores
    input wire [3:0] pump_source_enables, // source bits
    input wire [3:0] pump_sink_enables, // sink bits
    input wire [11:0] pump_source_ua, // source current
    input wire [11:0] pump_sink_ua // sink current
);
    // all checks on the one clock; all but reset_fields_a quiet while reset is held
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    rd_answer_a: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read strobe not answered");
    rvalid_pulse_a: assert property (!cfg_rd |=> !cfg_rvalid)
        else $error("read answer without strobe");
    miss_flag_a: assert property ((cfg_rd || cfg_wr) && cfg_addr == 16'h0207 |=> !cfg_hit)
        else $error("unmapped access flagged");
    map_hit_a: assert property ((cfg_rd || cfg_wr) && cfg_addr == 16'h020F |=> cfg_hit)
        else $error("mapped access not flagged");
    crystal_ref_a: assert property (!$past(sys_rst) |->
        cal_ref_from_crystal == !$past(synth_standalone)) else $error("bad cal source");
    source_current_a: assert property (!$past(sys_rst) |-> pump_source_ua ==
        ($past(pump_enable) ? 12'(12'h01F4 * $countones($past(pump_core_enables)
        & $past(pump_source_enables))) : 12'h0000)) else $error("bad source current");
    sink_current_a: assert property (!$past(sys_rst) |-> pump_sink_ua ==
        ($past(pump_enable) ? 12'(12'h00FA * $countones($past(pump_core_enables)
        & $past(pump_sink_enables))) : 12'h0000)) else $error("bad sink current");
    dither_amp_a: assert property (!$past(sys_rst) |->
        dither_amplitude_lsb == 4'h1 << $past(mod_dither_gain)) else $error("bad dither amp");
    ratio_flag_a: assert property (!$past(sys_rst) |-> frac_ratio_ok ==
        ($past(frac_numerator) < $past(frac_denominator))) else $error("bad ratio flag");
    den_write_a: assert property (cfg_wr && cfg_addr == 16'h020A |=>
        frac_denominator[23:16] == $past(cfg_wdata)) else $error("den byte not written");
    field_hold_a: assert property (!cfg_wr && !sys_rst |=>
        $stable(frac_numerator) && $stable(mod_order)) else $error("field moved unwritten");
    // the reset check itself must run while reset is high
    reset_fields_a: assert property (disable iff (1'b0) sys_rst |=>
        mod_order == 2'h3 && pump_core_enables == 4'hF) else $error("bad reset value");
endmodule

bind pll2_cfg_bank pll2_cfg_bank_properties props (.*);

// File: tb/pll2_cfg_bank_bench.sv
// self-checking bench for the second pll configuration bank
`timescale 1ns/1ps
module pll2_cfg_bank_bench;
    logic clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, synth_standalone = 1'b1;
    logic [15:0] cfg_addr = 16'h0000; // byte address
    logic [7:0] cfg_wdata = 8'h00; // write byte
    wire [7:0] cfg_rdata;
    wire cfg_rvalid, cfg_hit, vco_cal_enable, cal_ref_from_crystal, fractional_mode_select;
    wire frac_ratio_ok, mod_dither_enable, mod_dither_shaping, pump_enable;
    wire [13:0] vco_cal_ref_divisor;
    wire [23:0] frac_numerator, frac_denominator;
    wire [1:0] mod_dither_gain, mod_order;
    wire [3:0] dither_amplitude_lsb, pump_core_enables, pump_source_enables, pump_sink_enables;
    wire [11:0] pump_source_ua, pump_sink_ua;
    int fails = 0, comparisons = 0;
    // mapped bytes, their reset values and their writable bits
    logic [15:0] ad [13] = '{16'h0201, 16'h0202, 16'h0203, 16'h0204, 16'h0205, 16'h0206,
        16'h0208, 16'h0209, 16'h020A, 16'h020C, 16'h020D, 16'h020E, 16'h020F};
    logic [7:0] rv [13] = '{8'h80, 8'h75, 8'h06, 8'h00, 8'h00, 8'h43, 8'h00, 8'h00, 8'h7D,
        8'h06, 8'h80, 8'h0F, 8'hF0};
    logic [7:0] mk [13] = '{8'h80, 8'hFF, 8'hBF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h7E, 8'h80, 8'h0F, 8'hFF};

    always #12.5 clk = ~clk; // 40 mhz

    pll2_cfg_bank uut (.*);

    // value compare, four-state so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one write strobe, then an idle edge before the next request
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask

    // read answer stands one cycle only, so look right after the strobe edge
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
        @(posedge clk);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge clk);
        cfg_rd <= 1'b0;
        #1;
        chk(cfg_rdata, e);
        chk({cfg_rvalid, cfg_hit}, {1'b1, h});
    endtask

    // lets the derived outputs follow a field change
    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop;
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        // second pass is a reset in mid-run over written fields
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            sys_rst <= 1'b1;
            repeat (4) @(posedge clk);
            sys_rst <= 1'b0;
            for (int i = 0; i < 13; i++) rd(ad[i], rv[i], 1'b1);
            chk({pump_source_ua, pump_sink_ua}, {12'h07D0, 12'h0000});
            chk({dither_amplitude_lsb, frac_ratio_ok}, {4'h1, 1'b1});
            if (p == 0) begin
                // unmapped bytes take nothing and read zero
                wr(16'h0207, 8'hFF);
                rd(16'h0207, 8'h00, 1'b0);
                for (int i = 0; i < 13; i++) wr(ad[i], 8'hFF);
                for (int i = 0; i < 13; i++) rd(ad[i], mk[i], 1'b1);
                chk(frac_ratio_ok, 1'b0);
                // every writable bit is now set; the field outputs must show it too
                chk(frac_numerator, 24'hFF_FFFF);
                chk(frac_denominator, 24'hFF_FFFF);
                chk({vco_cal_ref_divisor, pump_core_enables, pump_source_enables}, 22'h3F_FFFF);
                chk({pump_sink_enables, pump_enable}, 5'h1F);
                chk({mod_dither_enable, mod_dither_shaping}, 2'h3);
                chk({mod_dither_gain, mod_order}, 4'hF);
                chk({vco_cal_enable, fractional_mode_select}, 2'h3);
                // gain and order share a byte: g<<3 | g<<1 is g*10
                for (int g = 0; g < 4; g++) begin
                    wr(16'h020C, 8'(g * 10));
                    settle();
                    chk({dither_amplitude_lsb, mod_order}, {4'h1 << g, 2'(g)});
                end
                // cores 0110, source 1010, sink 0101: one core each way
                wr(16'h020E, 8'h06);
                wr(16'h020F, 8'hA5);
                settle();
                chk({pump_source_ua, pump_sink_ua}, {12'h01F4, 12'h00FA});
                wr(16'h020D, 8'h00);
                settle();
                chk({pump_source_ua, pump_sink_ua}, 32'h0000_0000);
                @(posedge clk);
                synth_standalone <= 1'b0;
                settle();
                chk(cal_ref_from_crystal, 1'b1);
                // 25 mhz reference, 2500 mhz vco: 16384 * 25 / (2 * 2500 / 10) gives 819
                wr(16'h0202, 8'h33);
                wr(16'h0203, 8'h83);
                settle();
                chk({vco_cal_enable, vco_cal_ref_divisor}, {1'b1, 14'h0333});
                // integer division first, then fractional as the modulator needs
                wr(16'h0201, 8'h7F);
                settle();
                chk(fractional_mode_select, 1'b0);
                wr(16'h0201, 8'h80);
                settle();
                chk(fractional_mode_select, 1'b1);
            end
        end
        report_and_stop();
    end
endmodule
